// >>> pkg/fgrc_params.svh
// Register map, field positions and reset values of the frame capture block
`ifndef FGRC_PARAMS_SVH
`define FGRC_PARAMS_SVH

// Widths
`define FGRC_ADDR_W     8
`define FGRC_CNT_W      16
`define FGRC_SMP_W      8

// Register byte offsets
`define FGRC_A_CTRL     8'h00
`define FGRC_A_CFG      8'h04
`define FGRC_A_SPR      8'h08
`define FGRC_A_RPB      8'h0c
`define FGRC_A_RPA      8'h10
`define FGRC_A_STAT     8'h14
`define FGRC_A_FRAME    8'h18

// Control register command bits, self clearing
`define FGRC_CTRL_START 0
`define FGRC_CTRL_ABORT 1
`define FGRC_CTRL_FORCE 2

// Reset values of the count registers
`define FGRC_SPR_RST    16'h0100
`define FGRC_RPB_RST    16'h0010
`define FGRC_RPA_RST    16'h0040

// Sign flip between offset binary and two's complement
`define FGRC_SIGN_FLIP  8'h80

// AXI responses
`define FGRC_RESP_OKAY  2'h0
`define FGRC_RESP_SLV   2'h2

// Aux output selections
`define FGRC_SEL_BUSY   2'h0
`define FGRC_SEL_ARMED  2'h1
`define FGRC_SEL_TRIG   2'h2
`define FGRC_SEL_REC    2'h3

`endif

// >>> pkg/fgrc_pkg.sv
// Types shared by the frame gated record capture block
package fgrc_pkg;
`include "fgrc_params.svh"

    // Acquisition sequence, Gray coded along the usual path
    typedef enum logic [1:0]
    {
        FGRC_IDLE      = 2'h0,
        FGRC_WAIT_ARM  = 2'h1,
        FGRC_WAIT_LINE = 2'h3,
        FGRC_RECORD    = 2'h2
    } fgrc_state_t;

    // Configuration register, bit 0 first from the right
    typedef struct packed {
        logic       slave;
        logic [1:0] aux_sel;
        logic       infinite;
        logic       signed_fmt;
        logic       no_pretrigger_mode;
        logic       footer_en;
        logic       fall_edge;
        logic       aux_out_mode;
    } fgrc_cfg_t;

    // Raw converter sample, offset binary
    typedef struct packed {
        logic                   valid;
        logic [`FGRC_SMP_W-1:0] data;
    } fgrc_sample_t;

    // Captured record stream with optional frame footer
    typedef struct packed {
        logic                   valid;
        logic                   first;
        logic                   last;
        logic [`FGRC_SMP_W-1:0] data;
        logic                   footer_valid;
        logic [`FGRC_CNT_W-1:0] footer;
    } fgrc_rec_t;

    // Whole state of the top module, apart from the check counter h_cnt
    typedef struct packed {
        fgrc_cfg_t              cfg;
        logic [`FGRC_CNT_W-1:0] spr;
        logic [`FGRC_CNT_W-1:0] rpb;
        logic [`FGRC_CNT_W-1:0] rpa;
        fgrc_state_t            st;
        logic [`FGRC_CNT_W-1:0] smp_cnt;
        logic [`FGRC_CNT_W-1:0] rec_cnt;
        logic [`FGRC_CNT_W-1:0] acq_cnt;
        logic [`FGRC_CNT_W-1:0] frame;
        logic [2:0]             aux_s;
        logic [2:0]             trg_s;
        logic [2:0]             syn_s;
        logic                   cmd_start;
        logic                   cmd_abort;
        logic                   cmd_force;
        logic                   sync_out;
        logic                   aux_o;
        logic                   aux_oe_n;
        logic                   awready;
        logic                   wready;
        logic                   aw_got;
        logic                   w_got;
        logic [`FGRC_ADDR_W-1:0] awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arready;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
        fgrc_rec_t              out;
    } fgrc_regs_t;

endpackage

// >>> rtl/fgrc_top.sv
// Frame gated record capture with AXI4-Lite register slave
//
// Contract
// - Each line trigger captures one fixed-length record
// - Aux input active edge arms one frame
// - Take buffer of records, then ignore triggers
// - Software force arms exactly one frame
// - Aux output mode: drive signal, force-only arming
// - Infinite acquisition runs until host aborts
// - Footer mode counts frames, appends frame number
// - Footers only in no-pretrigger mode
// - Master start command starts all boards together
// - Misaligned records shift silently, no indication
// - Default output unsigned offset binary codes
// - Signed selection gives two's complement codes
// - Format written before start, readable back
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "fgrc_params.svh"

module fgrc_top
(
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // AXI4-Lite write channels
    input  wire logic [`FGRC_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [`FGRC_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Converter samples and record stream
    input  wire fgrc_pkg::fgrc_sample_t   samp_in,
    output fgrc_pkg::fgrc_rec_t           rec_out,
    // Line trigger pin
    input  wire logic                     line_trig_in,
    // Aux connector, two-way
    input  wire logic                     aux_in,
    output logic                          aux_out,
    output logic                          aux_oe_n,
    // Master-slave start link
    input  wire logic                     sync_start_in,
    output logic                          sync_start_out
);

    fgrc_pkg::fgrc_regs_t r;
    fgrc_pkg::fgrc_regs_t n;

    logic aux_evt;
    logic trg_evt;
    logic syn_evt;
    logic footer_mode;
    logic rec_end;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] fgrc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction

    // Edge detectors compare the second and third synchroniser stages
    assign aux_evt = r.cfg.fall_edge ? (r.aux_s[2] & ~r.aux_s[1])
                                     : (r.aux_s[1] & ~r.aux_s[2]);
    assign trg_evt = r.trg_s[1] & ~r.trg_s[2];
    assign syn_evt = r.syn_s[1] & ~r.syn_s[2];
    // Footers only exist in no-pretrigger mode
    assign footer_mode = r.cfg.footer_en &
                         r.cfg.no_pretrigger_mode;
    // Length is not checked: odd lengths shift silently
    assign rec_end = (r.st == fgrc_pkg::FGRC_RECORD) & samp_in.valid &
                     (r.smp_cnt + 16'h1 >= r.spr);

    // Next state of the whole block
    always_comb
    begin
        logic [31:0] mrg;
        logic        acq_done;
        n = r;
        mrg = 32'h0;
        acq_done = 1'b0;
        // Pin synchronisers, stage 0 read only by stage 1
        n.aux_s = {r.aux_s[1], r.aux_s[0], aux_in};
        n.trg_s = {r.trg_s[1], r.trg_s[0], line_trig_in};
        n.syn_s = {r.syn_s[1], r.syn_s[0], sync_start_in};
        n.cmd_start = 1'b0;
        n.cmd_abort = 1'b0;
        n.cmd_force = 1'b0;
        n.sync_out = 1'b0;
        n.out.valid = 1'b0;
        n.out.first = 1'b0;
        n.out.last = 1'b0;
        n.out.footer_valid = 1'b0;

        // Write address and data taken in either order
        if (s_axi_awvalid && r.awready)
        begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wready)
        begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `FGRC_RESP_OKAY;
            unique case (r.awaddr)
                `FGRC_A_CTRL:
                begin
                    if (r.wstrb[0])
                    begin
                        n.cmd_start = r.wdata[`FGRC_CTRL_START];
                        n.cmd_abort = r.wdata[`FGRC_CTRL_ABORT];
                        n.cmd_force = r.wdata[`FGRC_CTRL_FORCE];
                    end
                end
                `FGRC_A_CFG:
                begin
                    // Frozen while busy, so the format cannot change
                    // mid-acquisition
                    if (r.st == fgrc_pkg::FGRC_IDLE)
                    begin
                        mrg = fgrc_merge({23'h0, r.cfg}, r.wdata, r.wstrb);
                        n.cfg = fgrc_pkg::fgrc_cfg_t'(mrg[8:0]);
                    end
                end
                `FGRC_A_SPR:
                begin
                    mrg = fgrc_merge({16'h0, r.spr}, r.wdata, r.wstrb);
                    n.spr = mrg[15:0];
                end
                `FGRC_A_RPB:
                begin
                    mrg = fgrc_merge({16'h0, r.rpb}, r.wdata, r.wstrb);
                    n.rpb = mrg[15:0];
                end
                `FGRC_A_RPA:
                begin
                    mrg = fgrc_merge({16'h0, r.rpa}, r.wdata, r.wstrb);
                    n.rpa = mrg[15:0];
                end
                `FGRC_A_STAT, `FGRC_A_FRAME: ;
                default: n.bresp = `FGRC_RESP_SLV;
            endcase
        end
        if (r.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        n.awready = ~n.aw_got & ~n.bvalid;
        n.wready = ~n.w_got & ~n.bvalid;

        // Read answered one cycle after the address is taken
        if (s_axi_arvalid && r.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = `FGRC_RESP_OKAY;
            unique case (s_axi_araddr)
                `FGRC_A_CTRL:  n.rdata = 32'h0;
                `FGRC_A_CFG:   n.rdata = {23'h0, r.cfg};
                `FGRC_A_SPR:   n.rdata = {16'h0, r.spr};
                `FGRC_A_RPB:   n.rdata = {16'h0, r.rpb};
                `FGRC_A_RPA:   n.rdata = {16'h0, r.rpa};
                `FGRC_A_STAT:  n.rdata = {r.rec_cnt, 13'h0, r.st,
                                          r.st != fgrc_pkg::FGRC_IDLE};
                `FGRC_A_FRAME: n.rdata = {16'h0, r.frame};
                default:
                begin
                    n.rdata = 32'h0;
                    n.rresp = `FGRC_RESP_SLV;
                end
            endcase
        end
        else if (r.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        n.arready = ~n.rvalid;

        // Frame numbers counted on the aux input in footer mode
        if (footer_mode && !r.cfg.aux_out_mode && aux_evt)
            n.frame = r.frame + 16'h1;

        // Acquisition sequence
        unique case (r.st)
            fgrc_pkg::FGRC_IDLE:
            begin
                // A slave waits for the master's start edge
                if ((r.cmd_start && !r.cfg.slave) ||
                    (syn_evt && r.cfg.slave))
                begin
                    n.sync_out = ~r.cfg.slave;
                    n.acq_cnt = 16'h0;
                    n.rec_cnt = 16'h0;
                    n.frame = 16'h0;
                    n.st = footer_mode ? fgrc_pkg::FGRC_WAIT_LINE
                                       : fgrc_pkg::FGRC_WAIT_ARM;
                end
            end
            fgrc_pkg::FGRC_WAIT_ARM:
            begin
                // Line triggers ignored until armed
                if (r.cmd_force ||
                    (aux_evt && !r.cfg.aux_out_mode))
                begin
                    n.rec_cnt = 16'h0;
                    n.st = fgrc_pkg::FGRC_WAIT_LINE;
                end
            end
            fgrc_pkg::FGRC_WAIT_LINE:
            begin
                if (trg_evt)
                begin
                    n.smp_cnt = 16'h0;
                    n.st = fgrc_pkg::FGRC_RECORD;
                end
            end
            fgrc_pkg::FGRC_RECORD:
            begin
                // Triggers during a record are dropped
                if (samp_in.valid)
                begin
                    n.out.valid = 1'b1;
                    n.out.first = (r.smp_cnt == 16'h0);
                    n.out.last = rec_end;
                    // Raw codes are offset binary already
                    n.out.data = r.cfg.signed_fmt
                        ? (samp_in.data ^ `FGRC_SIGN_FLIP)
                        : samp_in.data;
                    n.smp_cnt = r.smp_cnt + 16'h1;
                end
                if (rec_end)
                begin
                    n.out.footer_valid = footer_mode;
                    n.out.footer = r.frame;
                    n.rec_cnt = r.rec_cnt + 16'h1;
                    n.acq_cnt = r.acq_cnt + 16'h1;
                    acq_done = !r.cfg.infinite &&
                               (r.acq_cnt + 16'h1 >= r.rpa);
                    if (acq_done)
                        n.st = fgrc_pkg::FGRC_IDLE;
                    else if (!footer_mode &&
                             r.rec_cnt + 16'h1 >= r.rpb)
                        n.st = fgrc_pkg::FGRC_WAIT_ARM;
                    else
                        n.st = fgrc_pkg::FGRC_WAIT_LINE;
                end
            end
        endcase
        // Abort wins over every state transition in flight
        if (r.cmd_abort)
            n.st = fgrc_pkg::FGRC_IDLE;

        // Aux connector in output mode
        n.aux_oe_n = ~n.cfg.aux_out_mode;
        unique case (r.cfg.aux_sel)
            `FGRC_SEL_BUSY:  n.aux_o = r.st != fgrc_pkg::FGRC_IDLE;
            `FGRC_SEL_ARMED: n.aux_o = r.st[1];
            `FGRC_SEL_TRIG:  n.aux_o = r.trg_s[2];
            `FGRC_SEL_REC:   n.aux_o = r.st == fgrc_pkg::FGRC_RECORD;
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= fgrc_pkg::FGRC_IDLE;
            r.spr <= `FGRC_SPR_RST;
            r.rpb <= `FGRC_RPB_RST;
            r.rpa <= `FGRC_RPA_RST;
            r.aux_oe_n <= 1'b1;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
        end
        else
            r <= n;
    end

    // Outputs straight from the state register
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rdata = r.rdata;
    assign rec_out = r.out;
    assign aux_out = r.aux_o;
    assign aux_oe_n = r.aux_oe_n;
    assign sync_start_out = r.sync_out;

    // Sample count within the current record, read only by checks
    logic [`FGRC_CNT_W-1:0] h_cnt;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            h_cnt <= 16'h0;
        else if (r.out.valid)
            h_cnt <= r.out.last ? 16'h0 : h_cnt + 16'h1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_waiting_arm;
        r.st == fgrc_pkg::FGRC_WAIT_ARM && !r.cmd_abort;
    endsequence
    sequence s_armed_fresh;
        r.st == fgrc_pkg::FGRC_WAIT_LINE && r.rec_cnt == 16'h0;
    endsequence

    property p_rec_len;
        r.out.valid && r.out.last |-> h_cnt + 16'h1 == r.spr;
    endproperty
    a_rec_len: assert property (p_rec_len)
        else $error("record length differs from setting");

    property p_aux_arm;
        s_waiting_arm ##0 (aux_evt && !r.cfg.aux_out_mode)
            |=> s_armed_fresh;
    endproperty
    a_aux_arm: assert property (p_aux_arm)
        else $error("aux edge did not arm a frame");

    property p_ignore_trig;
        (r.st == fgrc_pkg::FGRC_WAIT_ARM && !r.cmd_force && !aux_evt)
            |=> r.st != fgrc_pkg::FGRC_RECORD;
    endproperty
    a_ignore_trig: assert property (p_ignore_trig)
        else $error("line trigger taken while unarmed");

    property p_force_arm;
        s_waiting_arm ##0 r.cmd_force |=> s_armed_fresh;
    endproperty
    a_force_arm: assert property (p_force_arm)
        else $error("force command did not arm a frame");

    property p_out_mode;
        r.cfg.aux_out_mode [*2] |-> !r.aux_oe_n;
    endproperty
    a_out_mode: assert property (p_out_mode)
        else $error("aux not driven in output mode");

    property p_infinite;
        rec_end && r.cfg.infinite && !r.cmd_abort
            |=> r.st != fgrc_pkg::FGRC_IDLE;
    endproperty
    a_infinite: assert property (p_infinite)
        else $error("infinite acquisition stopped");

    property p_footer;
        r.out.last |-> r.out.footer_valid ==
            (r.cfg.footer_en && r.cfg.no_pretrigger_mode);
    endproperty
    a_footer: assert property (p_footer)
        else $error("footer presence wrong");

    property p_master;
        r.st == fgrc_pkg::FGRC_IDLE && r.cmd_start && !r.cfg.slave
            |=> sync_start_out && r.st != fgrc_pkg::FGRC_IDLE;
    endproperty
    a_master: assert property (p_master)
        else $error("master start not propagated");

    property p_unsigned;
        r.st == fgrc_pkg::FGRC_RECORD && samp_in.valid &&
            !r.cfg.signed_fmt |=> r.out.data == $past(samp_in.data);
    endproperty
    a_unsigned: assert property (p_unsigned)
        else $error("unsigned code altered");

    property p_signed;
        r.st == fgrc_pkg::FGRC_RECORD && samp_in.valid &&
            r.cfg.signed_fmt
            |=> r.out.data == ($past(samp_in.data) ^ `FGRC_SIGN_FLIP);
    endproperty
    a_signed: assert property (p_signed)
        else $error("signed code wrong");

endmodule

// >>> testbench/fgrc_far_side.sv
// Far-side model: frame source, line trigger source and converter stream
`timescale 1ns/1ns

module fgrc_far_side
(
    // Clock
    input  wire logic              mclk,
    // Pins toward the device
    output fgrc_pkg::fgrc_sample_t samp,
    output logic                   aux_drv,
    output logic                   line_trig
);
    // Pins start quiet
    initial
    begin
        samp = '0;
        aux_drv = 1'b0;
        line_trig = 1'b0;
    end

    // Converter code steps every cycle so both sign halves are crossed
    always @(posedge mclk)
    begin
        samp.valid <= 1'b1;
        samp.data  <= samp.data + 8'h01;
    end

    // TTL frame level, held long enough to pass the synchronisers
    task automatic aux_set(input logic v);
        @(posedge mclk);
        aux_drv <= v;
        repeat (6) @(posedge mclk);
    endtask

    // One line trigger pulse; the gap covers a short record
    task automatic line_pulse();
        @(posedge mclk);
        line_trig <= 1'b1;
        repeat (5) @(posedge mclk);
        line_trig <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// >>> testbench/fgrc_top_bench.sv
// Self-checking bench of the frame capture block over AXI4-Lite
`timescale 1ns/1ns
`include "fgrc_params.svh"
`define CHK(n, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("unexpected %s expected %h seen %h", n, e, g); \
        end \
    end

module fgrc_top_bench;
    logic [7:0]             s_axi_awaddr, s_axi_araddr, prev;
    logic [31:0]            s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp, rd_resp;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                   s_axi_rready, mclk, rst_n, sgn;
    logic                   line_trig_in, aux_in, aux_out, aux_oe_n;
    logic                   far_aux, sync_start_in, sync_start_out;
    logic [15:0]            foot;
    fgrc_pkg::fgrc_sample_t samp_in;
    fgrc_pkg::fgrc_rec_t    rec_out;
    int                     fail_count, check_count, recs, firsts;
    int                     words, foots, starts;
    localparam logic [7:0]  RA [5] = '{`FGRC_A_CTRL, `FGRC_A_CFG,
        `FGRC_A_SPR, `FGRC_A_RPB, `FGRC_A_RPA};
    localparam logic [31:0] RV [5] = '{32'h0, 32'h0, 32'h100, 32'h10, 32'h40};

    fgrc_top fgrc_top_inst
    (
        .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .samp_in, .rec_out, .line_trig_in,
        .aux_in, .aux_out, .aux_oe_n, .sync_start_in, .sync_start_out
    );
    fgrc_far_side fgrc_far_side_inst
    (
        .mclk, .samp(samp_in), .aux_drv(far_aux), .line_trig(line_trig_in)
    );

    // Aux wire level: the device wins while its enable is low
    assign aux_in = aux_oe_n ? far_aux : aux_out;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    // Record watcher; the code out is the raw code of the cycle before
    always @(posedge mclk)
    begin
        if (rec_out.valid)
            `CHK("record data", prev ^ {sgn, 7'h00}, rec_out.data)
        words  <= words + int'(rec_out.valid);
        recs   <= recs + int'(rec_out.valid && rec_out.last);
        firsts <= firsts + int'(rec_out.valid && rec_out.first);
        foots  <= foots + int'(rec_out.footer_valid);
        starts <= starts + int'(sync_start_out);
        if (rec_out.footer_valid)
            foot <= rec_out.footer;
        prev <= samp_in.data;
    end

    // One transfer; both channels of a write are offered together
    task automatic acc(input bit we, input logic [7:0] a, input logic [31:0] d);
        bit ha, hw, tr;
        int n;
        tr = 1'b0;
        n = 0;
        // New request one edge after the last release
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        // Sampled mid-cycle so the handshake edge is never raced
        while (!tr && n < 100)
        begin
            @(negedge mclk);
            n++;
            ha = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
            hw = s_axi_wvalid & s_axi_wready;
            tr = (s_axi_bready & s_axi_bvalid) | (s_axi_rready & s_axi_rvalid);
            rd_data = s_axi_rdata;
            rd_resp = we ? s_axi_bresp : s_axi_rresp;
            @(posedge mclk);
            s_axi_awvalid <= s_axi_awvalid & ~ha;
            s_axi_arvalid <= s_axi_arvalid & ~ha;
            s_axi_wvalid <= s_axi_wvalid & ~hw;
            s_axi_bready <= s_axi_bready & ~tr;
            s_axi_rready <= s_axi_rready & ~tr;
        end
        if (!tr)
            `CHK("bus answer", 1'b1, tr)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
        acc(1'b0, a, 32'h0);
        `CHK(s, e, rd_data)
    endtask

    // Busy and state bits of the status word
    task automatic st(input logic [2:0] e);
        acc(1'b0, `FGRC_A_STAT, 32'h0);
        `CHK("status", e, rd_data[2:0])
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog, well past the few hundred cycles the tests need
    initial
    begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        results();
    end

    // Main sequence
    initial
    begin
        {mclk, rst_n, sgn, sync_start_in, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {fail_count, check_count, recs, firsts, words, foots, starts} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 5; i++)
            rdc(RA[i], RV[i], "reset value");
        acc(1'b0, 8'h1c, 32'h0);
        `CHK("unmapped read", `FGRC_RESP_SLV, rd_resp)
        wr(8'h1c, 32'h1);
        `CHK("unmapped write", `FGRC_RESP_SLV, rd_resp)
        s_axi_wstrb <= 4'h0;
        wr(`FGRC_A_SPR, 32'hff);
        s_axi_wstrb <= 4'hf;
        rdc(`FGRC_A_SPR, 32'h100, "masked write");
        `CHK("aux enable", 1'b1, aux_oe_n)
        endt("registers");
        wr(`FGRC_A_SPR, 32'h4);
        wr(`FGRC_A_RPB, 32'h2);
        wr(`FGRC_A_RPA, 32'h6);
        wr(`FGRC_A_CTRL, 32'h1);
        st(3'h3);
        `CHK("start pulses", 1, starts)
        fgrc_far_side_inst.line_pulse();
        `CHK("records unarmed", 0, recs)
        fgrc_far_side_inst.aux_set(1'b1);
        st(3'h7);
        fgrc_far_side_inst.aux_set(1'b0);
        repeat (2) fgrc_far_side_inst.line_pulse();
        `CHK("records", 2, recs)
        `CHK("first flags", 2, firsts)
        `CHK("words", 8, words)
        st(3'h3);
        fgrc_far_side_inst.line_pulse();
        `CHK("records after frame", 2, recs)
        wr(`FGRC_A_CTRL, 32'h4);
        st(3'h7);
        repeat (2) fgrc_far_side_inst.line_pulse();
        st(3'h3);
        `CHK("forced frame words", 16, words)
        wr(`FGRC_A_CTRL, 32'h2);
        st(3'h0);
        endt("frame gate");
        wr(`FGRC_A_CFG, 32'h12);
        sgn <= 1'b1;
        rdc(`FGRC_A_CFG, 32'h12, "format readback");
        fgrc_far_side_inst.aux_set(1'b1);
        wr(`FGRC_A_CTRL, 32'h1);
        fgrc_far_side_inst.aux_set(1'b0);
        st(3'h7);
        fgrc_far_side_inst.aux_set(1'b1);
        fgrc_far_side_inst.line_pulse();
        `CHK("signed records", 5, recs)
        wr(`FGRC_A_CTRL, 32'h2);
        endt("signed falling edge");
        wr(`FGRC_A_CFG, 32'h01);
        sgn <= 1'b0;
        `CHK("aux drive enable", 1'b0, aux_oe_n)
        wr(`FGRC_A_CTRL, 32'h1);
        repeat (2) @(posedge mclk);
        `CHK("aux busy level", 1'b1, aux_out)
        fgrc_far_side_inst.aux_set(1'b0);
        fgrc_far_side_inst.aux_set(1'b1);
        st(3'h3);
        wr(`FGRC_A_CTRL, 32'h4);
        st(3'h7);
        wr(`FGRC_A_CTRL, 32'h2);
        endt("aux output");
        wr(`FGRC_A_RPB, 32'h1);
        wr(`FGRC_A_RPA, 32'h1);
        wr(`FGRC_A_CFG, 32'h20);
        wr(`FGRC_A_CTRL, 32'h1);
        repeat (2)
        begin
            wr(`FGRC_A_CTRL, 32'h4);
            fgrc_far_side_inst.line_pulse();
            st(3'h3);
        end
        `CHK("endless records", 7, recs)
        wr(`FGRC_A_CTRL, 32'h2);
        st(3'h0);
        endt("infinite");
        wr(`FGRC_A_CFG, 32'h0c);
        wr(`FGRC_A_CTRL, 32'h1);
        st(3'h7);
        repeat (2)
        begin
            fgrc_far_side_inst.aux_set(1'b0);
            fgrc_far_side_inst.aux_set(1'b1);
        end
        fgrc_far_side_inst.line_pulse();
        `CHK("footers", 1, foots)
        `CHK("footer frame", 16'h2, foot)
        rdc(`FGRC_A_FRAME, 32'h2, "frame number");
        wr(`FGRC_A_CTRL, 32'h2);
        wr(`FGRC_A_CFG, 32'h04);
        wr(`FGRC_A_CTRL, 32'h1);
        wr(`FGRC_A_CTRL, 32'h4);
        fgrc_far_side_inst.line_pulse();
        `CHK("footers outside mode", 1, foots)
        wr(`FGRC_A_CTRL, 32'h2);
        endt("footers");
        wr(`FGRC_A_CFG, 32'h100);
        wr(`FGRC_A_CTRL, 32'h1);
        st(3'h0);
        sync_start_in <= 1'b1;
        repeat (5) @(posedge mclk);
        sync_start_in <= 1'b0;
        repeat (4) @(posedge mclk);
        st(3'h3);
        wr(`FGRC_A_CTRL, 32'h2);
        endt("slave start");
        results();
    end
endmodule
